// ===== verilog/dsor_readout.sv
// dsor_readout: core-side readout of the filtered and composite serial ports
// assumes: results arrive on core_clk; enables, shift clocks and conversion
// clock come from the host; the host never selects two drivers at once
`timescale 1ns/1ps
`default_nettype none
module dsor_readout (
  // clocks and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  input  wire logic                                filtered_shift_clock,
  input  wire logic                                direct_shift_clock,
  // host pins
  input  wire logic                                conversion_start_clock,
  input  wire logic                                filtered_read_enable_n,
  input  wire logic                                direct_read_enable_n,
  output logic                                     filtered_serial_out,
  output logic                                     filtered_serial_oe,
  output logic                                     direct_serial_out,
  output logic                                     direct_serial_oe,
  output logic                                     filtered_data_ready,
  output logic                                     busy,
  // filtered results from the filter
  input  wire logic [dsor_pkg::FILT_WORD_W-1:0]    filt_result,
  input  wire logic [dsor_pkg::TAG_W-1:0]          filter_setting_tag,
  input  wire logic                                filt_valid,
  output logic                                     filt_ready,
  // conversion results from the converter core
  input  wire logic signed [dsor_pkg::RAW_DIFF_W-1:0] raw_diff,
  input  wire logic [dsor_pkg::CM_W-1:0]           common_mode,
  input  wire logic                                conv_valid,
  output logic                                     conv_ready
);

  localparam int unsigned FW = dsor_pkg::FILT_FRAME_W;
  localparam int unsigned DW = dsor_pkg::DIRECT_W;

  // countdown step shared by both output valid delays
  function automatic logic [dsor_pkg::DLY_W-1:0] dly_next(
    input logic                        load,
    input logic [dsor_pkg::DLY_W-1:0]  cur
  );
    if (load) begin
      dly_next = dsor_pkg::DLY_LOAD;
    end else if (cur != '0) begin
      dly_next = cur - 1'b1;
    end else begin
      dly_next = cur;
    end
  endfunction

  // pin synchronisers: bit 0 filtered enable, 1 direct enable, 2 conversion clock
  logic [2:0] pin_raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] stable_q;

  assign pin_raw = {conversion_start_clock, direct_read_enable_n, filtered_read_enable_n};

  // stages reset to each pin's idle level, so no false start edge follows reset
  localparam logic [2:0] PIN_IDLE = 3'b011;

  // a change counts only once the second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          s1_q[gi]     <= PIN_IDLE[gi];
          s2_q[gi]     <= PIN_IDLE[gi];
          s3_q[gi]     <= PIN_IDLE[gi];
          stable_q[gi] <= PIN_IDLE[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            stable_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic start_prev_q;
  logic start_edge;
  logic filt_frozen;
  logic dir_frozen;

  // a selected port freezes its word so the shift domain reads it settled
  assign filt_frozen = ~stable_q[0];
  assign dir_frozen  = ~stable_q[1];
  assign start_edge  = stable_q[2] & ~start_prev_q;

  // two-entry buffer: filtered word plus tag, waits while the port is read
  logic [FW-1:0] buf_mem [dsor_pkg::BUF_DEPTH];
  logic          wr_ptr_q;
  logic          rd_ptr_q;
  logic [1:0]    buf_cnt_q;
  logic [1:0]    buf_cnt_d;
  logic          buf_push;
  logic          buf_pop;
  logic [FW-1:0] filt_pub_q;

  assign buf_push  = filt_valid & filt_ready;
  assign buf_pop   = (buf_cnt_q != 2'h0) & ~filt_frozen;
  assign buf_cnt_d = buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};

  // tag is appended below the result word
  always_ff @(posedge core_clk) begin
    if (buf_push) begin
      buf_mem[wr_ptr_q] <= {filt_result, filter_setting_tag};
    end
  end

  // pointers and ready from a flop, so a full buffer stalls the filter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      buf_cnt_q  <= 2'h0;
      filt_ready <= 1'b0;
      filt_pub_q <= '0;
    end else begin
      wr_ptr_q   <= wr_ptr_q ^ buf_push;
      rd_ptr_q   <= rd_ptr_q ^ buf_pop;
      buf_cnt_q  <= buf_cnt_d;
      filt_ready <= (buf_cnt_d != 2'(dsor_pkg::BUF_DEPTH));
      if (buf_pop) begin
        filt_pub_q <= buf_mem[rd_ptr_q];
      end
    end
  end

  // composite word: saturation check and clamp
  logic                             ovr;
  logic [dsor_pkg::DIFF_W-1:0]      diff_clamp;
  logic [DW-1:0]                    comp_word;

  assign ovr        = (raw_diff > dsor_pkg::DIFF_MAX) | (raw_diff < dsor_pkg::DIFF_MIN);
  assign diff_clamp = ~ovr ? raw_diff[dsor_pkg::DIFF_W-1:0] :
                      (raw_diff[dsor_pkg::RAW_DIFF_W-1] ? dsor_pkg::DIFF_MIN[dsor_pkg::DIFF_W-1:0]
                                                         : dsor_pkg::DIFF_MAX[dsor_pkg::DIFF_W-1:0]);
  assign comp_word  = {ovr, diff_clamp, common_mode};

  // composite holding stage; one pending word is enough at one per conversion
  logic          pend_valid_q;
  logic [DW-1:0] pend_word_q;
  logic [DW-1:0] dir_pub_q;
  logic          conv_take;
  logic          dir_publish;

  assign conv_take   = conv_valid & conv_ready;
  assign dir_publish = pend_valid_q & ~dir_frozen;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_valid_q <= 1'b0;
      pend_word_q  <= '0;
      dir_pub_q    <= '0;
      conv_ready   <= 1'b0;
    end else begin
      if (conv_take) begin
        pend_word_q <= comp_word;
      end
      pend_valid_q <= conv_take | (pend_valid_q & ~dir_publish);
      conv_ready   <= ~(conv_take | (pend_valid_q & ~dir_publish));
      if (dir_publish) begin
        dir_pub_q <= pend_word_q;
      end
    end
  end

  // busy and data ready fall one output valid delay after the word settles
  logic [dsor_pkg::DLY_W-1:0] bdly_q;
  logic [dsor_pkg::DLY_W-1:0] fdly_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_prev_q        <= 1'b0;
      bdly_q              <= '0;
      fdly_q              <= '0;
      busy                <= 1'b0;
      filtered_data_ready <= 1'b1;
    end else begin
      start_prev_q <= stable_q[2];
      bdly_q       <= dly_next(dir_publish, bdly_q);
      fdly_q       <= dly_next(buf_pop, fdly_q);
      if (start_edge) begin
        busy <= 1'b1;
      end else if (bdly_q == 4'h1) begin
        busy <= 1'b0;
      end
      if (start_edge) begin
        filtered_data_ready <= 1'b1;
      end else if (fdly_q == 4'h1) begin
        filtered_data_ready <= 1'b0;
      end
    end
  end

  // link-side shifters, each on its own host shift clock
  dsor_shift_port #(.W(FW)) u_filt_port (
    .shift_clk     (filtered_shift_clock),
    .rst           (rst),
    .read_enable_n (filtered_read_enable_n),
    .serial_out    (filtered_serial_out),
    .serial_oe     (filtered_serial_oe),
    .word          (filt_pub_q)
  );

  dsor_shift_port #(.W(DW)) u_dir_port (
    .shift_clk     (direct_shift_clock),
    .rst           (rst),
    .read_enable_n (direct_read_enable_n),
    .serial_out    (direct_serial_out),
    .serial_oe     (direct_serial_oe),
    .word          (dir_pub_q)
  );

  // published filtered word stays put while its port is selected
  filt_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (filt_frozen && $past(filt_frozen)) |-> $stable(filt_pub_q))
    else $error("filtered word changed during a read");

  // published composite word stays put while its port is selected
  dir_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (dir_frozen && $past(dir_frozen)) |-> $stable(dir_pub_q))
    else $error("composite word changed during a read");

  // busy falls one output valid delay after publishing; written for a one-cycle delay
  busy_fall_a: assert property (@(posedge core_clk) disable iff (rst)
    (dir_publish ##1 !start_edge) |-> (bdly_q == dsor_pkg::DLY_LOAD) ##1 !busy)
    else $error("busy did not fall after delay");

  // data ready low once the delay has run after a filtered publish
  drl_fall_a: assert property (@(posedge core_clk) disable iff (rst)
    (fdly_q == 4'h1 && !start_edge) |=> !filtered_data_ready)
    else $error("data ready did not fall after delay");

  // overrange bit matches the saturation check
  ovr_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    conv_take |=> (pend_word_q[dsor_pkg::OVR_POS] ==
                   ($past(raw_diff) > dsor_pkg::DIFF_MAX || $past(raw_diff) < dsor_pkg::DIFF_MIN)))
    else $error("overrange bit wrong");

  // common mode sits in the low seven bits
  comp_layout_a: assert property (@(posedge core_clk) disable iff (rst)
    conv_take |=> (pend_word_q[dsor_pkg::CM_W-1:0] == $past(common_mode)))
    else $error("common mode field misplaced");

  // tag trails the result word
  tag_append_a: assert property (@(posedge core_clk) disable iff (rst)
    (buf_push && buf_cnt_q == 2'h0 && !filt_frozen) |=>
      ##1 (filt_pub_q[dsor_pkg::TAG_W-1:0] == $past(filter_setting_tag, 2)))
    else $error("tag not appended");

  // buffer never exceeds its depth
  buf_bound_a: assert property (@(posedge core_clk) disable iff (rst)
    (buf_cnt_q == 2'h2) |-> !filt_ready)
    else $error("buffer accepts while full");

  // deselected direct port never drives
  oe_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    (stable_q[1] && s3_q[1] && s2_q[1]) |-> !direct_serial_oe || !direct_read_enable_n)
    else $error("direct port drives while deselected");

endmodule
`default_nettype wire

// ===== include/dsor_pkg.sv
// dsor_pkg: shared constants for the dual serial output readout block
// assumes: a 25 MHz core clock; the shift clocks come from the host controller
package dsor_pkg;

  // core clock and output valid delay
  localparam int unsigned CORE_CLK_PERIOD_NS    = 40;
  localparam int unsigned OUTPUT_VALID_DELAY_NS = 40;
  localparam int unsigned OUTPUT_VALID_DELAY_RAW = OUTPUT_VALID_DELAY_NS / CORE_CLK_PERIOD_NS;
  localparam int unsigned OUTPUT_VALID_DELAY_CYC = (OUTPUT_VALID_DELAY_RAW < 1) ? 1 : OUTPUT_VALID_DELAY_RAW;
  localparam int unsigned DLY_W                  = 4;
  localparam logic [3:0]  DLY_LOAD               = 4'(OUTPUT_VALID_DELAY_CYC);

  // filtered frame: result word followed by the filter setting tag
  localparam int unsigned FILT_WORD_W  = 32;
  localparam int unsigned TAG_W        = 8;
  localparam int unsigned FILT_FRAME_W = FILT_WORD_W + TAG_W;

  // composite word layout
  localparam int unsigned DIRECT_W     = 32;
  localparam int unsigned OVR_POS      = 31;
  localparam int unsigned DIFF_W       = 24;
  localparam int unsigned DIFF_LSB     = 7;
  localparam int unsigned CM_W         = 7;
  localparam int unsigned CM_LSB       = 0;
  localparam int unsigned RAW_DIFF_W   = 26;

  // digital saturation limits of the differential value
  localparam logic signed [25:0] DIFF_MAX = 26'sh07fffff;
  localparam logic signed [25:0] DIFF_MIN = -26'sh0800000;

  // shift counter, buffer and synchroniser stages
  localparam int unsigned CNT_W     = 6;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned SYNC_N    = 3;

endpackage

// ===== verilog/dsor_shift_port.sv
// dsor_shift_port: one serial output port, clocked by the host's shift clock
// assumes: word is held still by the core while read_enable_n is low
`timescale 1ns/1ps
`default_nettype none
module dsor_shift_port #(
  parameter int unsigned W = 32
) (
  // link clock and reset
  input  wire logic         shift_clk,
  input  wire logic         rst,
  // pins
  input  wire logic         read_enable_n,
  output logic              serial_out,
  output logic              serial_oe,
  // word from the core domain, stable during a frame
  input  wire logic [W-1:0] word
);

  logic [dsor_pkg::CNT_W-1:0] cnt_q;
  logic                       frame_rst;
  logic [dsor_pkg::CNT_W-1:0] bit_idx;
  logic                       in_word;

  // the enable itself clears the count, so no shift edge is needed to start
  assign frame_rst = rst | read_enable_n;
  assign in_word   = (cnt_q < dsor_pkg::CNT_W'(W));
  assign bit_idx   = dsor_pkg::CNT_W'(W - 1) - cnt_q;

  // bit position advances once per rising shift edge, msb first
  always_ff @(posedge shift_clk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q <= '0;
    end else if (in_word) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  logic started_q;

  // marks a frame that has seen a shift edge, so $past never reaches into the previous frame
  always_ff @(posedge shift_clk or posedge frame_rst) begin
    if (frame_rst) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // line is driven only while this port is selected
  assign serial_oe  = ~read_enable_n & ~rst;
  assign serial_out = in_word ? word[bit_idx[$clog2(W)-1:0]] : 1'b0;

  // top bit on the line before the first shift edge
  first_bit_a: assert property (@(posedge shift_clk) disable iff (frame_rst)
    !started_q |-> (cnt_q == '0 && serial_out == word[W-1]))
    else $error("first bit is not the top bit");

  // one bit per shift edge while selected
  bit_step_a: assert property (@(posedge shift_clk) disable iff (frame_rst)
    (started_q && $past(in_word)) |-> (cnt_q == $past(cnt_q) + 1'b1))
    else $error("shift position skipped or stalled");

  // never drive while deselected
  oe_select_a: assert property (@(posedge shift_clk) disable iff (rst)
    serial_oe |-> !read_enable_n)
    else $error("port drives while deselected");

endmodule
`default_nettype wire

// ===== tb/dsor_host_model.sv
// dsor_host_model: host reading both serial ports over one shared data line
// assumes: the bench calls read_word; shift clocks stand still outside frames
`timescale 1ns/1ps
`default_nettype none
module dsor_host_model (
  // shift clocks and selects
  output logic     filtered_shift_clock,
  output logic     direct_shift_clock,
  output logic     filtered_read_enable_n,
  output logic     direct_read_enable_n,
  // device outputs
  input  wire logic f_out,
  input  wire logic f_oe,
  input  wire logic d_out,
  input  wire logic d_oe,
  // count of times both drivers turn on together
  output int       clash
);
  logic line_q;
  wire  sd;
  // released line shows the inverse of its last level, never a stale bit
  assign sd = f_oe ? f_out : d_oe ? d_out : ~line_q;
  // last driven level of the shared line
  always @(f_oe, d_oe, f_out, d_out) begin
    if (f_oe) line_q = f_out;
    else if (d_oe) line_q = d_out;
  end
  // two drivers at once on the shared line
  always @(posedge (f_oe & d_oe)) clash++;
  // idle: both selects high, clocks still
  initial begin
    filtered_shift_clock = 1'b0;
    direct_shift_clock = 1'b0;
    filtered_read_enable_n = 1'b1;
    direct_read_enable_n = 1'b1;
    clash = 0;
    line_q = 1'b0;
  end
  // one frame: select, sample, clock the next bit, deselect
  task automatic read_word(input bit dir, input int n, output logic [39:0] w);
    w = '0;
    if (dir) direct_read_enable_n = 1'b0;
    else filtered_read_enable_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        if (dir) direct_shift_clock = 1'b1;
        else filtered_shift_clock = 1'b1;
        #24;
      end
      if (dir) direct_shift_clock = 1'b0;
      else filtered_shift_clock = 1'b0;
      #24;
      w = {w[38:0], sd};
    end
    direct_read_enable_n = 1'b1;
    filtered_read_enable_n = 1'b1;
    // one idle shift period, so a back-to-back frame really deselects first
    #48;
  endtask
endmodule
`default_nettype wire

// ===== tb/dsor_readout_test.sv
// dsor_readout_test: bench for the readout with a host model on one shared line
// assumes: dsor_pkg compiled first; core inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dsor_readout_test;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic               conv_start = 1'b0;
  logic [31:0]        filt_result = '0;
  logic [7:0]         filter_tag = '0;
  logic               filt_valid = 1'b0;
  logic signed [25:0] raw_diff = '0;
  logic [6:0]         common_mode = '0;
  logic               conv_valid = 1'b0;
  wire                f_sck, d_sck, f_en_n, d_en_n, f_so, f_oe, d_so, d_oe;
  wire                data_ready, busy, filt_ready, conv_ready;
  int                 clash, fails = 0, n_compared = 0;
  // core clock, 40 ns
  always #20 core_clk = ~core_clk;
  dsor_readout u_dut (.core_clk(core_clk), .rst(rst), .filtered_shift_clock(f_sck),
    .direct_shift_clock(d_sck), .conversion_start_clock(conv_start),
    .filtered_read_enable_n(f_en_n), .direct_read_enable_n(d_en_n),
    .filtered_serial_out(f_so), .filtered_serial_oe(f_oe), .direct_serial_out(d_so),
    .direct_serial_oe(d_oe), .filtered_data_ready(data_ready), .busy(busy),
    .filt_result(filt_result), .filter_setting_tag(filter_tag), .filt_valid(filt_valid),
    .filt_ready(filt_ready), .raw_diff(raw_diff), .common_mode(common_mode),
    .conv_valid(conv_valid), .conv_ready(conv_ready));
  dsor_host_model u_host (.filtered_shift_clock(f_sck), .direct_shift_clock(d_sck),
    .filtered_read_enable_n(f_en_n), .direct_read_enable_n(d_en_n), .f_out(f_so),
    .f_oe(f_oe), .d_out(d_so), .d_oe(d_oe), .clash(clash));
  // counts, verdict and stop
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // valid already up: hold until ready, then drop at the next falling edge
  task automatic wait_rdy(input bit c);
    int k;
    for (k = 0; k < 60 && (c ? conv_ready : filt_ready) !== 1'b1; k++) @(negedge core_clk);
    if (k == 60) begin
      fails++;
      end_of_test();
    end
    @(negedge core_clk);
    filt_valid = 1'b0;
    conv_valid = 1'b0;
  endtask
  // bounded wait for busy or data ready to fall
  task automatic wait_low(input bit b);
    int k;
    for (k = 0; k < 200 && (b ? busy : data_ready) !== 1'b0; k++) @(negedge core_clk);
    if (k == 200) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic push_f(input logic [31:0] r, input logic [7:0] t);
    @(negedge core_clk);
    filt_result = r;
    filter_tag = t;
    filt_valid = 1'b1;
    wait_rdy(1'b0);
  endtask
  // filtered frame, then a stall that fills the buffer mid-read
  task automatic test_filtered();
    logic [39:0] w;
    push_f(32'hc35a_0f81, 8'h5a);
    wait_low(1'b0);
    u_host.read_word(1'b0, 40, w);
    `CHK(w, 40'hc35a_0f81_5a)
    fork
      u_host.read_word(1'b0, 40, w);
      begin
        repeat (10) @(negedge core_clk);
        push_f(32'h1234_5678, 8'h01);
        push_f(32'h8765_4321, 8'h80);
        `CHK(filt_ready, 1'b0)
      end
    join
    `CHK(w, 40'hc35a_0f81_5a)
    repeat (12) @(negedge core_clk);
    `CHK(filt_ready, 1'b1)
    u_host.read_word(1'b0, 40, w);
    `CHK(w, 40'h8765_4321_80)
    $display("test_filtered done");
  endtask
  // composite words at and beyond both saturation limits
  task automatic test_direct();
    logic signed [25:0] v [4] = '{26'sh07fffff, 26'sh0800000, -26'sh0800000, -26'sh0800001};
    logic [39:0] w;
    logic        ovr;
    logic [25:0] d;
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      conv_start = 1'b1;
      repeat (6) @(negedge core_clk);
      `CHK(busy, 1'b1)
      conv_start = 1'b0;
      raw_diff = v[i];
      common_mode = 7'h55 ^ 7'(i);
      conv_valid = 1'b1;
      wait_rdy(1'b1);
      wait_low(1'b1);
      ovr = v[i] > dsor_pkg::DIFF_MAX || v[i] < dsor_pkg::DIFF_MIN;
      d = !ovr ? v[i] : (v[i] > 0) ? dsor_pkg::DIFF_MAX : dsor_pkg::DIFF_MIN;
      u_host.read_word(1'b1, 32, w);
      `CHK(w[31:0], {ovr, d[23:0], common_mode})
    end
    $display("test_direct done");
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(data_ready, 1'b1)
    test_filtered();
    test_direct();
    `CHK({f_oe, d_oe}, 2'b00)
    `CHK(clash, 0)
    end_of_test();
  end
endmodule
`default_nettype wire
